// File: hdl/dcis_regs.vh
// constants of the dma channel interrupt status block
// assumes a 32-bit apb slave with byte addresses
//
// Notes on behaviour
// - busy bit mirrors selected channel busy
// - fetch-fault bit mirrors selected channel fault
// - halt flag reads selected; write one clears
// - completion flag reads selected; write one clears
// - transfer fault flag reads selected; one clears
// - selected field holds lowest pending channel unless an id was written
// - selection valid only when a flag set
// - refresh on lower channel or clear
// - no pending interrupt reads field zero
// - writing field selects channel indirectly
// - summary bit set when channel pending
// - summary clears on disable or clear
// - active bit sets when transfer starts
// - active clears on done, error, disable
// - reserved bits read zero, write zero
// - waiting bit sets on pending, clears on start, error, disable
// - waiting bit mirrors selected channel waiting
`ifndef DCIS_REGS_VH
`define DCIS_REGS_VH
`define DCIS_OFS_VIEW      8'h20
`define DCIS_OFS_SUMMARY   8'h24
`define DCIS_OFS_BUSY      8'h28
`define DCIS_OFS_WAIT      8'h2C
`define DCIS_BIT_WAITING   15
`define DCIS_BIT_ACTIVE    14
`define DCIS_BIT_FETCH     13
`define DCIS_BIT_HALT      10
`define DCIS_BIT_CMPL      9
`define DCIS_BIT_XFERR     8
`define DCIS_ID_MSB        2
`define DCIS_RESET_VALUE   32'h00000000
`endif

// File: hdl/dcis_flag_bank.v
// per-channel sticky interrupt flags: halt, completion, transfer fault
// assumes single-cycle event pulses from the channel engines
`timescale 1ns/1ps
module dcis_flag_bank #(
	parameter NCH = 6
) (
	// clock and reset
	input  wire           core_clk,
	input  wire           nrst,
	// events
	input  wire [NCH-1:0] setEvt,
	// write-one-to-clear
	input  wire [NCH-1:0] clrReq,
	// state
	output reg  [NCH-1:0] flag_ff
);
	// set wins over clear so a same-cycle event is never lost
	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			flag_ff <= {NCH{1'b0}};
		end else begin
			flag_ff <= (flag_ff & ~clrReq) | setEvt;
		end
	end
endmodule // dcis_flag_bank

// File: hdl/dcis_chan_vec.v
// per-channel set/clear status vector (active or waiting)
// assumes single-cycle set and clear pulses
`timescale 1ns/1ps
module dcis_chan_vec #(
	parameter NCH = 6
) (
	// clock and reset
	input  wire           core_clk,
	input  wire           nrst,
	// controls
	input  wire [NCH-1:0] setEvt,
	input  wire [NCH-1:0] clrEvt,
	// state
	output reg  [NCH-1:0] vec_ff
);
	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			vec_ff <= {NCH{1'b0}};
		end else begin
			vec_ff <= (vec_ff & ~clrEvt) | setEvt;
		end
	end
endmodule // dcis_chan_vec

// File: hdl/dcis_status.v
// status and interrupt reporting of a six-channel dma controller
// assumes apb master on core_clk; channel events are one-cycle pulses
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
`include "dcis_regs.vh"
module dcis_status #(
	parameter NCH = 6
) (
	// clock and reset
	input  wire           core_clk,
	input  wire           nrst,
	// apb slave
	input  wire           psel,
	input  wire           penable,
	input  wire           pwrite,
	input  wire [7:0]     paddr,
	input  wire [31:0]    pwdata,
	output reg  [31:0]    prdata,
	output reg            pready,
	output reg            pslverr,
	// channel engine events
	input  wire [NCH-1:0] xferStart,
	input  wire [NCH-1:0] trigDone,
	input  wire [NCH-1:0] busErr,
	input  wire [NCH-1:0] chanDisable,
	input  wire [NCH-1:0] xferPending,
	input  wire [NCH-1:0] trigStart,
	input  wire [NCH-1:0] fetchFault,
	input  wire [NCH-1:0] haltEvt,
	input  wire [NCH-1:0] cmplEvt,
	input  wire [NCH-1:0] xferErrEvt,
	input  wire [NCH-1:0] irqEnable,
	// interrupt request
	output reg            irqOut
);
	// per-channel state; fetch fault is held here, the rest in the sub-blocks
	wire [NCH-1:0] haltFlag;
	wire [NCH-1:0] cmplFlag;
	wire [NCH-1:0] xferErrFlag;
	wire [NCH-1:0] activeVec;
	wire [NCH-1:0] waitVec;
	reg  [NCH-1:0] fetchFlag_ff;
	reg  [NCH-1:0] nxt_fetchFlag;

	// channel selection
	reg  [2:0]     selId_ff;
	reg  [2:0]     nxt_selId;
	wire [NCH-1:0] flagVec;
	wire           anyFlag;
	wire [2:0]     lowestId;
	wire           heldFlagged;
	wire           lowerArrived;

	// write-one-to-clear strobes
	reg  [NCH-1:0] clrHalt;
	reg  [NCH-1:0] clrCmpl;
	reg  [NCH-1:0] clrXferErr;

	// address decode and bus phases
	wire           hitView;
	wire           hitSummary;
	wire           hitBusy;
	wire           hitWait;
	wire           hitAny;
	wire           setupPh;
	wire           rdSetup;
	wire           wrAcc;
	wire           wrView;

	// selected-channel view bits
	reg            selWaiting;
	reg            selActive;
	reg            selFetch;
	reg            selHalt;
	reg            selCmpl;
	reg            selXferErr;

	// register words and output next values
	wire [NCH-1:0] summary;
	reg  [31:0]    viewWord;
	reg  [31:0]    summaryWord;
	reg  [31:0]    busyWord;
	reg  [31:0]    waitWord;
	reg  [31:0]    nxt_prdata;
	reg            nxt_pready;
	reg            nxt_pslverr;
	reg            nxt_irqOut;

	// lowest set bit; zero when none
	function [2:0] lowestSet;
		input [NCH-1:0] v;
		integer i;
		begin
			lowestSet = 3'h0;
			for (i = NCH - 1; i >= 0; i = i - 1) begin
				if (v[i]) begin
					lowestSet = i[2:0];
				end
			end
		end
	endfunction

	// bit of the selected channel; ids past the last channel read zero
	function pick;
		input [NCH-1:0] v;
		input [2:0]     id;
		begin
			pick = (id < NCH) ? v[id] : 1'b0;
		end
	endfunction

	// true when the bus address names the given register word
	function hitOfs;
		input [7:0] addr;
		input [7:0] ofs;
		begin
			hitOfs = (addr == ofs);
		end
	endfunction

	// channel vector in the low bits; reserved bits stay zero
	function [31:0] chanWord;
		input [NCH-1:0] v;
		begin
			chanWord = `DCIS_RESET_VALUE;
			chanWord[NCH-1:0] = v;
		end
	endfunction

	// data is captured in setup, writes land in the access cycle
	assign setupPh = psel & ~penable;
	assign rdSetup = setupPh & ~pwrite;
	assign wrAcc   = psel & penable & pwrite & pready;

	assign hitView    = hitOfs(paddr, `DCIS_OFS_VIEW);
	assign hitSummary = hitOfs(paddr, `DCIS_OFS_SUMMARY);
	assign hitBusy    = hitOfs(paddr, `DCIS_OFS_BUSY);
	assign hitWait    = hitOfs(paddr, `DCIS_OFS_WAIT);
	assign hitAny     = hitView | hitSummary | hitBusy | hitWait;
	assign wrView     = wrAcc & hitView;

	assign flagVec      = haltFlag | cmplFlag | xferErrFlag;
	assign anyFlag      = |flagVec;
	assign lowestId     = lowestSet(flagVec);
	assign heldFlagged  = pick(flagVec, selId_ff);
	assign lowerArrived = (lowestId < selId_ff);
	assign summary      = flagVec & irqEnable;

	// w1c decode to the selected channel only
	always @* begin
		clrHalt    = {NCH{1'b0}};
		clrCmpl    = {NCH{1'b0}};
		clrXferErr = {NCH{1'b0}};
		if (wrView && selId_ff < NCH) begin
			clrHalt[selId_ff]    = pwdata[`DCIS_BIT_HALT];
			clrCmpl[selId_ff]    = pwdata[`DCIS_BIT_CMPL];
			clrXferErr[selId_ff] = pwdata[`DCIS_BIT_XFERR];
		end
	end

	// halt, completion and transfer fault flags
	dcis_flag_bank #(.NCH(NCH)) uHalt (
		.core_clk (core_clk),
		.nrst     (nrst),
		.setEvt   (haltEvt),
		.clrReq   (clrHalt),
		.flag_ff  (haltFlag)
	);
	dcis_flag_bank #(.NCH(NCH)) uCmpl (
		.core_clk (core_clk),
		.nrst     (nrst),
		.setEvt   (cmplEvt),
		.clrReq   (clrCmpl),
		.flag_ff  (cmplFlag)
	);
	dcis_flag_bank #(.NCH(NCH)) uXferErr (
		.core_clk (core_clk),
		.nrst     (nrst),
		.setEvt   (xferErrEvt),
		.clrReq   (clrXferErr),
		.flag_ff  (xferErrFlag)
	);

	// active and waiting vectors
	dcis_chan_vec #(.NCH(NCH)) uActive (
		.core_clk (core_clk),
		.nrst     (nrst),
		.setEvt   (xferStart),
		.clrEvt   (trigDone | busErr | chanDisable),
		.vec_ff   (activeVec)
	);
	dcis_chan_vec #(.NCH(NCH)) uWait (
		.core_clk (core_clk),
		.nrst     (nrst),
		.setEvt   (xferPending),
		.clrEvt   (trigStart | busErr | chanDisable),
		.vec_ff   (waitVec)
	);

	// fetch fault is sticky until the channel is disabled
	always @* begin
		nxt_fetchFlag = fetchFault
			| (fetchFlag_ff & ~chanDisable);
	end

	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			fetchFlag_ff <= {NCH{1'b0}};
		end else begin
			fetchFlag_ff <= nxt_fetchFlag;
		end
	end

	// a written id lasts only while it stays flagged and no lower channel is flagged
	always @* begin
		nxt_selId = selId_ff;
		if (wrView) begin
			nxt_selId = pwdata[`DCIS_ID_MSB:0];
		end else if (!anyFlag) begin
			nxt_selId = 3'h0;
		end else if (lowerArrived || !heldFlagged) begin
			nxt_selId = lowestId;
		end
	end

	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			selId_ff <= 3'h0;
		end else begin
			selId_ff <= nxt_selId;
		end
	end

	// flags of the selected channel
	always @* begin
		selWaiting = pick(waitVec, selId_ff);
		selActive  = pick(activeVec, selId_ff);
		selFetch   = pick(fetchFlag_ff, selId_ff);
		selHalt    = pick(haltFlag, selId_ff);
		selCmpl    = pick(cmplFlag, selId_ff);
		selXferErr = pick(xferErrFlag, selId_ff);
	end

	// view word; bits 12:11 and 7:3 are reserved and stay zero
	always @* begin
		viewWord = `DCIS_RESET_VALUE;
		viewWord[`DCIS_BIT_WAITING] = selWaiting;
		viewWord[`DCIS_BIT_ACTIVE]  = selActive;
		viewWord[`DCIS_BIT_FETCH]   = selFetch;
		viewWord[`DCIS_BIT_HALT]    = selHalt;
		viewWord[`DCIS_BIT_CMPL]    = selCmpl;
		viewWord[`DCIS_BIT_XFERR]   = selXferErr;
		viewWord[`DCIS_ID_MSB:0]    = selId_ff;
	end

	always @* begin
		summaryWord = chanWord(summary);
		busyWord    = chanWord(activeVec);
		waitWord    = chanWord(waitVec);
	end

	// read mux; an unmapped address reads zero with a slave error
	always @* begin
		nxt_prdata = `DCIS_RESET_VALUE;
		if (hitView) begin
			nxt_prdata = viewWord;
		end else if (hitSummary) begin
			nxt_prdata = summaryWord;
		end else if (hitBusy) begin
			nxt_prdata = busyWord;
		end else if (hitWait) begin
			nxt_prdata = waitWord;
		end
		nxt_pslverr = ~hitAny;
	end

	// ready one cycle after setup: exactly one access cycle
	always @* begin
		nxt_pready = setupPh;
		nxt_irqOut = |summary;
	end

	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			prdata  <= `DCIS_RESET_VALUE;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= nxt_pready;
			pslverr <= setupPh & nxt_pslverr;
			if (rdSetup) begin
				prdata <= nxt_prdata;
			end
		end
	end

	// kept apart from the bus registers; one cycle behind the flags
	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			irqOut <= 1'b0;
		end else begin
			irqOut <= nxt_irqOut;
		end
	end
endmodule // dcis_status

// File: test/dcis_status_assertions.sv
// port checker for the dma channel status block
// assumes it is bound onto dcis_status
`timescale 1ns/1ps
module dcis_status_chk #(
	parameter NCH = 6
) (
	// clock and reset
	input logic           core_clk,
	input logic           nrst,
	// apb
	input logic           psel,
	input logic           penable,
	input logic           pwrite,
	input logic [7:0]     paddr,
	input logic [31:0]    prdata,
	input logic           pready,
	input logic           pslverr,
	// interrupt side
	input logic [NCH-1:0] cmplEvt,
	input logic [NCH-1:0] irqEnable,
	input logic           irqOut
);
	logic mapped;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	assign mapped = paddr[7:4] == 4'h2 && paddr[1:0] == 2'h0;
	sequence setupPh; psel && !penable; endsequence
	sequence readAck; pready && !pwrite; endsequence
	sequence vecRead; readAck ##0 paddr != 8'h20; endsequence
	sequence viewRead; readAck ##0 paddr == 8'h20; endsequence
	sequence cmplSeen; (cmplEvt & irqEnable) != 6'h00; endsequence
	a_ready_once: assert property (setupPh |=> pready)
		else $error("late ready");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready too long");
	a_err_unmapped: assert property (pready && !mapped |-> pslverr)
		else $error("no slave error");
	a_err_data: assert property (readAck ##0 pslverr |-> prdata == 32'h0)
		else $error("error read not zero");
	a_vec_reserved: assert property (vecRead |->
		prdata[31:6] == 26'h0) else $error("vector reserved");
	a_view_reserved: assert property (viewRead |->
		prdata[31:16] == 16'h0 && prdata[12:11] == 2'h0 &&
		prdata[7:3] == 5'h0) else $error("view reserved");
	a_irq_raise: assert property (cmplSeen |->
		##[1:2] irqOut) else $error("irq not raised");
	a_irq_masked: assert property ((irqEnable == 6'h00) [*2] |=>
		!irqOut) else $error("masked irq seen");
endmodule // dcis_status_chk
bind dcis_status dcis_status_chk #(.NCH(NCH)) u_chk (
	.core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .cmplEvt(cmplEvt), .irqEnable(irqEnable),
	.irqOut(irqOut));

// File: test/dma_channel_interrupt_status_tb.sv
// self-checking bench for the dma channel status block
// assumes dcis_status answering apb within a few cycles
`timescale 1ns/1ps
module dma_channel_interrupt_status_tb;
	logic core_clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, pready, pslverr, irqOut, rErr;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rdat;
	logic [5:0] irqEnable = 6'h00;
	logic [9:0][5:0] ev = '0;
	int errors = 0, checks = 0;
	// event lanes packed so one pulse task serves all ten inputs
	dcis_status #(.NCH(6)) DUT (.core_clk, .nrst, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.xferStart(ev[9]), .trigDone(ev[8]), .busErr(ev[7]),
		.chanDisable(ev[6]), .xferPending(ev[5]), .trigStart(ev[4]),
		.fetchFault(ev[3]), .haltEvt(ev[2]), .cmplEvt(ev[1]),
		.xferErrEvt(ev[0]), .irqEnable, .irqOut);
	initial forever #12.5 core_clk = ~core_clk;
	task chk(string s, logic [31:0] g, e);
		checks++;
		if (g !== e) begin
			errors++;
			$display("MISMATCH %s exp %h got %h", s, e, g);
		end
	endtask
	task results;
		$display("errors %0d checks %0d", errors, checks);
		if (errors == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task apb(logic w, logic [7:0] a, logic [31:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			errors++;
			results;
		end else begin
			rdat = prdata;
			rErr = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask
	task rd(logic [7:0] a, logic [31:0] e, string s);
		apb(1'b0, a, 32'h0);
		chk(s, rdat, e);
	endtask
	task pulse(int k, logic [5:0] m);
		@(posedge core_clk);
		ev[k] <= m;
		@(posedge core_clk);
		ev[k] <= 6'h00;
	endtask
	task t_reset;
		apb(1'b1, 8'h24, 32'h0000003F);
		rd(8'h24, 32'h0, "summary");
		rd(8'h28, 32'h0, "busy");
		rd(8'h2C, 32'h0, "wait");
		rd(8'h20, 32'h0, "view");
		rd(8'h30, 32'h0, "unmapped");
		chk("slverr", {31'h0, rErr}, 32'h1);
	endtask
	task t_vec(int s, c, logic [7:0] a, logic [5:0] m);
		pulse(s, m);
		rd(a, {26'h0, m}, "vec set");
		pulse(c, m);
		rd(a, 32'h0, "vec clear");
	endtask
	task t_irq;
		irqEnable <= 6'h3F;
		pulse(1, 6'h10);
		rd(8'h20, 32'h204, "cmpl view");
		rd(8'h24, 32'h10, "summary");
		chk("irq", {31'h0, irqOut}, 32'h1);
		pulse(0, 6'h02);
		rd(8'h20, 32'h101, "lower id");
		apb(1'b1, 8'h20, 32'h100);
		rd(8'h20, 32'h204, "fault clear");
		apb(1'b1, 8'h20, 32'h004);
		rd(8'h20, 32'h204, "zero write");
		pulse(9, 6'h10);
		pulse(5, 6'h10);
		pulse(3, 6'h10);
		rd(8'h20, 32'hE204, "status bits");
		apb(1'b1, 8'h20, 32'h200);
		rd(8'h20, 32'h0, "none left");
		rd(8'h24, 32'h0, "cleared");
		chk("irq off", {31'h0, irqOut}, 32'h0);
		irqEnable <= 6'h1F;
		pulse(2, 6'h20);
		rd(8'h24, 32'h0, "disabled");
		irqEnable <= 6'h3F;
		rd(8'h24, 32'h20, "enabled");
		rd(8'h20, 32'h405, "halt view");
		apb(1'b1, 8'h20, 32'h405);
		rd(8'h24, 32'h0, "halt clear");
	endtask
	initial begin
		repeat (5) @(posedge core_clk);
		nrst <= 1'b1;
		t_reset;
		t_vec(9, 8, 8'h28, 6'h04);
		t_vec(9, 7, 8'h28, 6'h20);
		t_vec(9, 6, 8'h28, 6'h01);
		t_vec(5, 4, 8'h2C, 6'h08);
		t_vec(5, 7, 8'h2C, 6'h02);
		t_vec(5, 6, 8'h2C, 6'h10);
		t_irq;
		results;
	end
endmodule // dma_channel_interrupt_status_tb
